// >>> flash_cfg_pkg.sv
// Functional notes
// - Divider top bit status; low bits write once
// - Reset clears loaded flag; first write sets
// - Erase/program disabled until divisor loaded
// - Prescale bit selects bus or bus/8
// - Flash clock is input over divisor+1
// - Timing pulse one flash clock period
// - Options loaded from image just after reset release
// - Key enable zero refuses backdoor unlock
// - Matching 8-byte ordered key unsecures device
// - Key writes accepted only from secure code
// - Redirect disable bit turns redirection off
// - Only code 1:0 means unsecured
// - Secure device blocks unsecured memory access
// - Key match or blank check unsecures
// - Blocked write ignored, blocked read zero
// - Early program/erase sets access error
package flash_cfg_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CLOCK_DIVIDER = 12'h000;
    localparam logic [11:0] ADDR_OPTIONS       = 12'h004;
    localparam logic [11:0] ADDR_STATUS        = 12'h008;
    localparam logic [11:0] ADDR_KEY_CTRL      = 12'h00c;
    localparam logic [11:0] ADDR_KEY_DATA      = 12'h010;
    // ==========================================================
    // Field positions
    localparam int DIVISOR_LOADED_FLAG_BIT    = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int DIV_MSB      = 5;
    localparam int BACKDOOR_KEY_ENABLE_BIT    = 7;
    localparam int NORED_BIT    = 6;
    localparam int SEC_MSB      = 1;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] OPT_MASK      = 8'hc3;
    localparam logic [3:0] PRESCALE_DIV  = 4'h8;
    localparam int KEY_BYTES   = 8;
    // ==========================================================
    // Timing of the flash clock
    localparam int CLK_MHZ       = 125;
    localparam int PULSE_MIN_NS  = 5000;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
endpackage : flash_cfg_pkg

// >>> flash_clk_gen.sv
`timescale 1ns/100ps
// Enable-pulse divider that forms the internal flash clock
module flash_clk_gen
    import flash_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    // Settings
    input  wire logic       run_i,
    input  wire logic       prescale_i,
    input  wire logic [5:0] divisor_i,
    // Pulse out
    output logic            tick_o
);
    typedef struct packed {
        logic [3:0] pre;
        logic [5:0] cnt;
        logic       tick;
    } gen_state_t;

    gen_state_t st_reg;
    gen_state_t st_next;
    logic       pre_tick;

    // ==========================================================
    // Prescale stage then main divide
    always_comb
    begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        pre_tick     = 1'b1;
        if (prescale_i)
        begin
            pre_tick = (st_reg.pre == PRESCALE_DIV - 4'h1);
            st_next.pre = pre_tick ? 4'h0 : st_reg.pre + 4'h1;
        end
        if (!run_i)
        begin
            st_next.pre = 4'h0;
            st_next.cnt = 6'h00;
        end
        else if (pre_tick)
        begin
            if (st_reg.cnt >= divisor_i)
            begin
                st_next.cnt  = 6'h00;
                st_next.tick = 1'b1;
            end
            else
                st_next.cnt = st_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick_o = st_reg.tick;
endmodule : flash_clk_gen

// >>> flash_clock_divider_and_options.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
// Flash clock divider and options registers behind APB
module flash_clock_divider_and_options
    import flash_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Nonvolatile options image, stable around reset
    input  wire logic [7:0]  nonvolatile_options_image_i,
    input  wire logic [63:0] stored_backdoor_key_i,
    // Sequencer side
    input  wire logic        pe_request_i,
    input  wire logic        blank_check_ok_i,
    input  wire logic        master_secure_i,
    input  wire logic        mem_access_i,
    input  wire logic        mem_write_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             pe_enable_o,
    output logic             pe_start_o,
    output logic             flash_tick_o,
    output logic             secured_o,
    output logic             redirect_enable_o,
    output logic             mem_allow_o,
    output logic             mem_write_allow_o,
    output logic [7:0]       mem_rdata_o
);
    import flash_cfg_pkg::*;

    typedef struct packed {
        logic        divisor_loaded_flag;
        logic [6:0]  divbits;
        logic [7:0]  opts;
        logic        opt_loaded;
        logic        unlocked;
        logic        key_mode;
        logic [3:0]  key_idx;
        logic        key_match;
        logic        acc_err;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        pe_enable;
        logic        pe_start;
        logic        tick;
        logic        secured;
        logic        redir;
        logic        allow;
        logic        wallow;
        logic [7:0]  mrdata;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;
    logic       tick;
    logic       setup;
    logic       wr;
    logic       rd;
    logic       secure_now;
    logic [7:0] key_byte;

    // ==========================================================
    // Flash clock generator, runs once the divisor is loaded
    flash_clk_gen u_clk_gen
    (
        .mclk_i     (mclk_i),
        .reset_i    (reset_i),
        .run_i      (st_reg.divisor_loaded_flag),
        .prescale_i (st_reg.divbits[PRESCALE_BIT]),
        .divisor_i  (st_reg.divbits[DIV_MSB:0]),
        .tick_o     (tick)
    );

    // Access decode, single-cycle answer in access phase
    assign setup = psel_i & ~penable_i;
    // Write lands at the edge where pready is sampled high
    assign wr    = psel_i & penable_i & pwrite_i & st_reg.ready;
    assign rd    = setup & ~pwrite_i;
    assign key_byte = stored_backdoor_key_i[63 - 8*st_reg.key_idx[2:0] -: 8];

    assign secure_now = (st_reg.opts[SEC_MSB:0] != SEC_UNSECURED)
                        & ~st_reg.unlocked;

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        st_next          = st_reg;
        st_next.ready    = setup;
        st_next.slverr   = 1'b0;
        st_next.pe_start = 1'b0;
        st_next.tick     = tick;
        // options latched once after reset release
        if (!st_reg.opt_loaded)
        begin
            st_next.opts       = nonvolatile_options_image_i & OPT_MASK;
            st_next.opt_loaded = 1'b1;
        end
        if (rd)
        begin
            case (paddr_i)
                ADDR_CLOCK_DIVIDER:
                    st_next.rdata = {24'h0, st_reg.divisor_loaded_flag, st_reg.divbits};
                ADDR_OPTIONS:
                    st_next.rdata = {24'h0, st_reg.opts & OPT_MASK};
                ADDR_STATUS:
                    st_next.rdata = {29'h0, st_reg.acc_err,
                                     secure_now, st_reg.divisor_loaded_flag};
                ADDR_KEY_CTRL:
                    st_next.rdata = {31'h0, st_reg.key_mode};
                ADDR_KEY_DATA:
                    st_next.rdata = 32'h0;
                default:
                begin
                    st_next.rdata  = 32'h0;
                    st_next.slverr = 1'b1;
                end
            endcase
        end
        else if (setup)
        begin
            st_next.rdata = 32'h0;
            case (paddr_i)
                ADDR_CLOCK_DIVIDER, ADDR_OPTIONS, ADDR_STATUS,
                ADDR_KEY_CTRL, ADDR_KEY_DATA: st_next.slverr = 1'b0;
                default: st_next.slverr = 1'b1;
            endcase
        end
        if (wr && pstrb_i[0])
        begin
            case (paddr_i)
                ADDR_CLOCK_DIVIDER:
                begin
                    if (!st_reg.divisor_loaded_flag)
                    begin
                        st_next.divbits = pwdata_i[6:0];
                        st_next.divisor_loaded_flag   = 1'b1;
                    end
                end
                // Error flag clears on write one; set wins below
                ADDR_STATUS:
                    if (pwdata_i[2])
                        st_next.acc_err = 1'b0;
                ADDR_KEY_CTRL:
                begin
                    // key entry only from secure code
                    if (master_secure_i)
                    begin
                        if (pwdata_i[0] && !st_reg.key_mode)
                        begin
                            st_next.key_idx   = 4'h0;
                            st_next.key_match = 1'b1;
                        end
                        if (!pwdata_i[0] && st_reg.key_mode &&
                            st_reg.key_match &&
                            st_reg.key_idx == 4'(KEY_BYTES) &&
                            st_reg.opts[BACKDOOR_KEY_ENABLE_BIT])
                        begin
                            st_next.unlocked = 1'b1;
                            st_next.opts[SEC_MSB:0] = SEC_UNSECURED;
                        end
                        st_next.key_mode = pwdata_i[0];
                    end
                end
                ADDR_KEY_DATA:
                begin
                    if (master_secure_i && st_reg.key_mode)
                    begin
                        if (st_reg.key_idx >= 4'(KEY_BYTES) ||
                            pwdata_i[7:0] != key_byte)
                            st_next.key_match = 1'b0;
                        if (st_reg.key_idx < 4'(KEY_BYTES))
                            st_next.key_idx = st_reg.key_idx + 4'h1;
                    end
                end
                // Options read-only; unmapped flagged at setup already
                default: ;
            endcase
        end
        if (blank_check_ok_i)
        begin
            st_next.unlocked        = 1'b1;
            st_next.opts[SEC_MSB:0] = SEC_UNSECURED;
        end
        st_next.pe_enable = st_next.divisor_loaded_flag;
        // early request errors and is dropped
        if (pe_request_i)
        begin
            if (st_reg.divisor_loaded_flag)
                st_next.pe_start = 1'b1;
            else
                st_next.acc_err = 1'b1;
        end
        st_next.secured = (st_next.opts[SEC_MSB:0] != SEC_UNSECURED)
                          & ~st_next.unlocked;
        st_next.redir = ~st_next.opts[NORED_BIT];
        st_next.allow  = mem_access_i &
                         (master_secure_i | ~st_next.secured);
        st_next.wallow = st_next.allow & mem_write_i;
        st_next.mrdata = st_next.allow ? mem_rdata_i : 8'h00;
    end

    // ==========================================================
    // State register; options capture after release, not in reset
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_reg         <= '0;
            st_reg.secured <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from the state register
    // tick marks one flash clock period
    assign flash_tick_o      = st_reg.tick;
    assign prdata_o          = st_reg.rdata;
    assign pready_o          = st_reg.ready;
    assign pslverr_o         = st_reg.slverr;
    assign pe_enable_o       = st_reg.pe_enable;
    assign pe_start_o        = st_reg.pe_start;
    assign secured_o         = st_reg.secured;
    assign redirect_enable_o = st_reg.redir;
    assign mem_allow_o       = st_reg.allow;
    assign mem_write_allow_o = st_reg.wallow;
    assign mem_rdata_o       = st_reg.mrdata;
endmodule : flash_clock_divider_and_options

// >>> flash_cfg_chk.sv
`timescale 1ns/100ps
// Watches the flash configuration block from its ports
module flash_cfg_chk
    import flash_cfg_pkg::*;
(
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        reset_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Flash side
    input wire logic        pe_request_i,
    input wire logic        blank_check_ok_i,
    input wire logic        master_secure_i,
    input wire logic        mem_access_i,
    input wire logic        pe_enable_o,
    input wire logic        pe_start_o,
    input wire logic        flash_tick_o,
    input wire logic        secured_o,
    input wire logic        redirect_enable_o,
    input wire logic        mem_allow_o,
    input wire logic [7:0]  mem_rdata_o
);
    logic wr_seen_reg;
    logic rd_opt;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // ==========================================
    // Helpers: divider written, options read
    always_ff @(posedge mclk_i or posedge reset_i)
        if (reset_i)
            wr_seen_reg <= 1'b0;
        else if (psel_i && penable_i && pwrite_i
                 && paddr_i == ADDR_CLOCK_DIVIDER)
            wr_seen_reg <= 1'b1;
    assign rd_opt = psel_i && penable_i && pready_o && !pwrite_i
                    && paddr_i == ADDR_OPTIONS;
    // ==========================================
    // Assertions
    chk_ready_next: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing in access phase");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    chk_enable_cause: assert property (
        pe_enable_o |-> wr_seen_reg) else $error("loaded without write");
    chk_enable_hold: assert property (
        pe_enable_o |=> pe_enable_o) else $error("loaded flag dropped");
    chk_early_pe: assert property (
        pe_request_i && !pe_enable_o |=> !pe_start_o)
        else $error("operation started before divider load");
    chk_pe_start: assert property (
        pe_request_i && pe_enable_o |=> pe_start_o)
        else $error("enabled operation not started");
    chk_tick_gate: assert property (
        flash_tick_o |-> pe_enable_o) else $error("tick before load");
    chk_redirect_bit: assert property (
        rd_opt |-> prdata_o[NORED_BIT] == !redirect_enable_o)
        else $error("redirect output disagrees");
    chk_opt_mask: assert property (
        rd_opt |-> prdata_o[5:2] == 4'h0) else $error("reserved bits set");
    chk_sec_code: assert property (
        rd_opt |-> secured_o == (prdata_o[1:0] != SEC_UNSECURED))
        else $error("secure output disagrees with code");
    chk_mem_block: assert property (
        mem_access_i && !master_secure_i && secured_o
        |=> !mem_allow_o && mem_rdata_o == 8'h00)
        else $error("unsecured access not blocked");
    chk_blank_unsec: assert property (
        blank_check_ok_i |-> ##[1:2] !secured_o)
        else $error("blank check did not unsecure");
endmodule : flash_cfg_chk

// >>> tb.sv
`timescale 1ns/100ps
module tb;
    import flash_cfg_pkg::*;
    logic mclk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, pe_request_i = 0, blank_check_ok_i = 0;
    logic master_secure_i = 0, mem_access_i = 0, mem_write_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, seed = 32'h867b5328;
    logic [7:0] nv_img = 0, mem_rdata_i = 0, mem_rdata_o, img;
    logic [63:0] key_v = 0;
    logic pready_o, pslverr_o, pe_enable_o, pe_start_o, flash_tick_o;
    logic secured_o, redirect_enable_o, mem_allow_o, mem_write_allow_o;
    logic [32:0] exp_q[$];
    int error_cnt = 0, check_count = 0;
    always #4 mclk_i = ~mclk_i;
    flash_clock_divider_and_options dut (.mclk_i(mclk_i),
        .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .nonvolatile_options_image_i(nv_img),
        .stored_backdoor_key_i(key_v), .pe_request_i(pe_request_i),
        .blank_check_ok_i(blank_check_ok_i),
        .master_secure_i(master_secure_i), .mem_access_i(mem_access_i),
        .mem_write_i(mem_write_i), .mem_rdata_i(mem_rdata_i),
        .pe_enable_o(pe_enable_o), .pe_start_o(pe_start_o),
        .flash_tick_o(flash_tick_o), .secured_o(secured_o),
        .redirect_enable_o(redirect_enable_o), .mem_allow_o(mem_allow_o),
        .mem_write_allow_o(mem_write_allow_o), .mem_rdata_o(mem_rdata_o));
    // ==========================================
    // Compare and closing tasks
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %0t: read %h want %h", $time, g, e);
        end
    endtask : cmp_rd
    task automatic cmp_sig(input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %0t: signal %h want %h", $time, g, e);
        end
    endtask : cmp_sig
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // ==========================================
    // Drivers; upper write data random, must be ignored
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [8:0] e);
        logic [31:0] r;
        int n;
        n = 0;
        r = $random(seed);
        if (!w)
            exp_q.push_back({e[8], 24'h0, e[7:0]});
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {r[31:8], d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do
            @(posedge mclk_i);
        while (pready_o !== 1'b1 && n++ < 50);
        if (n >= 50)
        begin
            error_cnt++;
            $display("Error %0t: no pready", $time);
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic rst(input logic [7:0] v);
        @(posedge mclk_i);
        nv_img <= v;
        reset_i <= 1'b1;
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask : rst
    // One-cycle strobe: 0 request, 1 blank check, 2 memory access
    task automatic pulse(input int s);
        @(posedge mclk_i);
        mem_rdata_i <= 8'($random(seed));
        pe_request_i <= (s == 0);
        blank_check_ok_i <= (s == 1);
        mem_access_i <= (s == 2);
        mem_write_i <= (s == 2);
        @(posedge mclk_i);
        {pe_request_i, blank_check_ok_i, mem_access_i, mem_write_i} <= 4'h0;
        #1;
    endtask : pulse
    // Key entry; unlock is judged on leaving key mode
    task automatic key(input logic [63:0] k, input logic ms);
        master_secure_i <= ms;
        apb(1'b1, ADDR_KEY_CTRL, 8'h01, 9'h0);
        for (int i = 0; i < KEY_BYTES; i++)
            apb(1'b1, ADDR_KEY_DATA, k[63-8*i -: 8], 9'h0);
        apb(1'b1, ADDR_KEY_CTRL, 8'h00, 9'h0);
        repeat (2) @(posedge mclk_i);
        master_secure_i <= 1'b0;
    endtask : key
    task automatic tickp(input logic [15:0] e);
        logic [15:0] n;
        n = 0;
        do
            @(posedge mclk_i);
        while (flash_tick_o !== 1'b1 && ++n < 1000);
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (flash_tick_o !== 1'b1 && n < 1000);
        cmp_sig(e, n);
    endtask : tickp
    // Read result watcher
    always @(posedge mclk_i)
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
            cmp_rd(exp_q.pop_front(), {pslverr_o, prdata_o});
    initial
    begin
        #(8 * 30000);
        error_cnt++;
        give_verdict;
    end
    // ==========================================
    // Main sequence
    initial
    begin
        key_v <= {$random(seed), $random(seed)};
        for (int c = 0; c < 4; c++)
        begin
            img = 8'($random(seed));
            img[1:0] = c[1:0];
            rst(img);
            cmp_sig(img[1:0] != SEC_UNSECURED, secured_o);
            cmp_sig(!img[6], redirect_enable_o);
            apb(1'b0, ADDR_OPTIONS, 8'h0, {1'b0, img & OPT_MASK});
        end
        rst(8'hff);
        apb(1'b1, ADDR_OPTIONS, 8'h00, 9'h0);
        apb(1'b0, ADDR_OPTIONS, 8'h00, 9'h0c3);
        apb(1'b0, 12'h100, 8'h00, 9'h100);
        apb(1'b0, ADDR_CLOCK_DIVIDER, 8'h00, 9'h000);
        pulse(2);
        cmp_sig(0, {mem_allow_o, mem_write_allow_o});
        cmp_sig(0, mem_rdata_o);
        pulse(0);
        apb(1'b0, ADDR_STATUS, 8'h00, 9'h006);
        cmp_sig(0, pe_enable_o);
        // slowest setting; a 125 MHz bus stays above range
        apb(1'b1, ADDR_CLOCK_DIVIDER, 8'h7f, 9'h0);
        apb(1'b0, ADDR_CLOCK_DIVIDER, 8'h00, 9'h0ff);
        apb(1'b1, ADDR_CLOCK_DIVIDER, 8'h02, 9'h0);
        apb(1'b0, ADDR_CLOCK_DIVIDER, 8'h00, 9'h0ff);
        pulse(0);
        cmp_sig(1, pe_start_o);
        tickp(16'd512);
        key(key_v, 1'b0);
        cmp_sig(1, secured_o);
        key(key_v ^ 64'h1, 1'b1);
        cmp_sig(1, secured_o);
        key(key_v, 1'b1);
        cmp_sig(0, secured_o);
        apb(1'b0, ADDR_OPTIONS, 8'h00, 9'h0c2);
        pulse(2);
        cmp_sig({2'b11, mem_rdata_i},
                {mem_allow_o, mem_write_allow_o, mem_rdata_o});
        rst(8'h43);
        key(key_v, 1'b1);
        cmp_sig(1, secured_o);
        apb(1'b1, ADDR_CLOCK_DIVIDER, 8'h03, 9'h0);
        tickp(16'd4);
        pulse(1);
        repeat (2) @(posedge mclk_i);
        cmp_sig(0, secured_o);
        give_verdict;
    end
endmodule : tb
bind flash_clock_divider_and_options flash_cfg_chk u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pe_request_i(pe_request_i), .blank_check_ok_i(blank_check_ok_i),
    .master_secure_i(master_secure_i), .mem_access_i(mem_access_i),
    .pe_enable_o(pe_enable_o), .pe_start_o(pe_start_o),
    .flash_tick_o(flash_tick_o), .secured_o(secured_o),
    .redirect_enable_o(redirect_enable_o), .mem_allow_o(mem_allow_o),
    .mem_rdata_o(mem_rdata_o));
